// *** design/ucrm_channel_regs.sv ***
// Register map and address decode for one UART channel.
// Assumes host strobes are single-cycle, synchronous to clk, one per access.
// Overview of operation
// - Extended fields act only while enhanced-function bit 4 is set.
// - Address 0, divisor access off: read returns oldest received char.
// - Address 0, divisor access off: write loads transmit holding.
// - Divisor bytes at 0,1 when line-control bit 7 set and not key; fraction at 2 also needs bit 4.
// - Divisor access on and both divisor bytes zero: read revision at 0 and device id at 1.
// - Interrupt-enable at address 1 when line-control bit 7 clear.
// - Interrupt-status read-only at address 2 unless key or fraction mode.
// - FIFO-control write-only at address 2 unless key or fraction mode.
// - Line-control read/write at address 3.
// - Modem-control read/write at address 4 when not key.
// - Line-status read-only at address 5 when not key.
// - Enhanced-function read/write at address 2 under key.
// - Enhanced set reachable only while line-control holds key.
// - Own chip select and address lines pick this channel's set.
`timescale 1ns/1ps
`default_nettype none
module ucrm_channel_regs (
	input wire logic clk,
	input wire logic rst,
	input wire logic chipSel,
	input wire logic [2:0] addr,
	input wire logic readStb,
	input wire logic writeStb,
	input wire logic [7:0] wrData,
	output logic [7:0] rdData,
	input wire ucrm_pkg::ucrm_stat_s stat,
	output ucrm_pkg::ucrm_ctrl_s ctrl,
	output logic [7:0] transmitHolding,
	output logic txLoad,
	output logic rxRead,
	output logic fifoWrite,
	output logic lineStatusRead,
	output logic modemStatusRead,
	output logic intStatusRead
);
	// ****************************************
	// Mode decode
	// ****************************************
	logic [7:0] ienR;
	logic [7:0] fctlR;
	logic [7:0] lctlR;
	logic [7:0] mctlR;
	logic [7:0] divLoR;
	logic [7:0] divHiR;
	logic [7:0] divFrR;
	logic [7:0] efnR;
	logic [7:0] res1R;
	logic [7:0] res2R;
	logic [7:0] pau1R;
	logic [7:0] pau2R;
	logic [7:0] scrR;
	logic [7:0] rdDataNxt;
	logic keyMode;
	logic divMode;
	logic normMode;
	logic extOn;
	logic idMode;
	logic fracMode;
	logic wr;
	logic rd;
	logic [7:0] extKeep;

	assign wr = chipSel & writeStb;
	assign rd = chipSel & readStb;
	assign keyMode = (lctlR == ucrm_pkg::LCTL_KEY);
	assign divMode = lctlR[ucrm_pkg::LCTL_DIV_BIT] & ~keyMode;
	assign normMode = ~lctlR[ucrm_pkg::LCTL_DIV_BIT];
	assign extOn = efnR[ucrm_pkg::EFN_EXT_BIT];
	assign idMode = divMode & (divLoR == ucrm_pkg::ZERO_BYTE)
		& (divHiR == ucrm_pkg::ZERO_BYTE);
	// Fraction claims address 2 only with extensions on; else status
	assign fracMode = divMode & extOn;

	// Merge of a write into stored bits; extension bits held while en is clear
	function automatic logic [7:0] ucrm_merge(input logic [7:0] old,
		input logic [7:0] din, input logic [7:0] extMask, input logic en);
		logic [7:0] keep;
		keep = en ? 8'h00 : extMask;
		ucrm_merge = (old & keep) | (din & ~keep);
	endfunction : ucrm_merge

	assign extKeep = extOn ? 8'hff : 8'h00;

	// ****************************************
	// Compatible registers
	// ****************************************
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			lctlR <= ucrm_pkg::REG_RESET;
		end else if (wr && addr == ucrm_pkg::ADDR_LCTL) begin
			lctlR <= wrData;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ienR <= ucrm_pkg::REG_RESET;
		end else if (wr && normMode && addr == ucrm_pkg::ADDR_IEN) begin
			ienR <= ucrm_merge(ienR, wrData, ucrm_pkg::IEN_EXT_MASK,
				extOn);
		end
	end

	// FIFO-control sits at address 2 unless key or fraction mode owns it
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			fctlR <= ucrm_pkg::REG_RESET;
		end else if (wr && !keyMode && !fracMode
			&& addr == ucrm_pkg::ADDR_ISTAT) begin
			fctlR <= ucrm_merge(fctlR, wrData, ucrm_pkg::FCTL_EXT_MASK,
				extOn);
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			mctlR <= ucrm_pkg::REG_RESET;
		end else if (wr && !keyMode && addr == ucrm_pkg::ADDR_MCTL) begin
			mctlR <= ucrm_merge(mctlR, wrData, ucrm_pkg::MCTL_EXT_MASK,
				extOn);
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			scrR <= ucrm_pkg::REG_RESET;
		end else if (wr && !keyMode && addr == ucrm_pkg::ADDR_SCR) begin
			scrR <= wrData;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			transmitHolding <= ucrm_pkg::REG_RESET;
		end else if (wr && normMode && addr == ucrm_pkg::ADDR_HOLD) begin
			transmitHolding <= wrData;
		end
	end

	// ****************************************
	// Divisor registers
	// ****************************************
	// Divisor bytes stay writable in id mode so software can leave it
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			divLoR <= ucrm_pkg::REG_RESET;
			divHiR <= ucrm_pkg::REG_RESET;
		end else if (wr && divMode) begin
			if (addr == ucrm_pkg::ADDR_DIVLO) begin
				divLoR <= wrData;
			end
			if (addr == ucrm_pkg::ADDR_DIVHI) begin
				divHiR <= wrData;
			end
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			divFrR <= ucrm_pkg::REG_RESET;
		end else if (wr && divMode && extOn
			&& addr == ucrm_pkg::ADDR_DIVFR) begin
			divFrR <= wrData & ucrm_pkg::DIVFR_MASK;
		end
	end

	// ****************************************
	// Enhanced registers
	// ****************************************
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			efnR <= ucrm_pkg::REG_RESET;
			res1R <= ucrm_pkg::REG_RESET;
			res2R <= ucrm_pkg::REG_RESET;
			pau1R <= ucrm_pkg::REG_RESET;
			pau2R <= ucrm_pkg::REG_RESET;
		end else if (wr && keyMode) begin
			case (addr)
				ucrm_pkg::ADDR_EFN: efnR <= wrData;
				ucrm_pkg::ADDR_RES1: res1R <= wrData;
				ucrm_pkg::ADDR_RES2: res2R <= wrData;
				ucrm_pkg::ADDR_PAU1: pau1R <= wrData;
				ucrm_pkg::ADDR_PAU2: pau2R <= wrData;
				default: begin
				end
			endcase
		end
	end

	// ****************************************
	// Read mux
	// ****************************************
	always_comb begin
		rdDataNxt = ucrm_pkg::ZERO_BYTE;
		if (keyMode) begin
			case (addr)
				ucrm_pkg::ADDR_EFN: rdDataNxt = efnR;
				ucrm_pkg::ADDR_LCTL: rdDataNxt = lctlR;
				ucrm_pkg::ADDR_RES1: rdDataNxt = res1R;
				ucrm_pkg::ADDR_RES2: rdDataNxt = res2R;
				ucrm_pkg::ADDR_PAU1: rdDataNxt = pau1R;
				ucrm_pkg::ADDR_PAU2: rdDataNxt = pau2R;
				default: rdDataNxt = ucrm_pkg::ZERO_BYTE;
			endcase
		end else begin
			case (addr)
				ucrm_pkg::ADDR_HOLD: begin
					if (idMode) begin
						rdDataNxt = ucrm_pkg::REV_CODE;
					end else if (divMode) begin
						rdDataNxt = divLoR;
					end else begin
						rdDataNxt = stat.receiveHolding;
					end
				end
				ucrm_pkg::ADDR_IEN: begin
					if (idMode) begin
						rdDataNxt = ucrm_pkg::DEV_ID;
					end else if (divMode) begin
						rdDataNxt = divHiR;
					end else begin
						rdDataNxt = ienR & (extKeep
							| ~ucrm_pkg::IEN_EXT_MASK);
					end
				end
				ucrm_pkg::ADDR_ISTAT: begin
					if (fracMode) begin
						rdDataNxt = divFrR & ucrm_pkg::DIVFR_MASK;
					end else begin
						rdDataNxt = stat.interruptStatus & (extKeep
							| ~ucrm_pkg::ISTAT_EXT_MASK);
					end
				end
				ucrm_pkg::ADDR_LCTL: rdDataNxt = lctlR;
				ucrm_pkg::ADDR_MCTL: rdDataNxt = mctlR & (extKeep
					| ~ucrm_pkg::MCTL_EXT_MASK);
				ucrm_pkg::ADDR_LSTAT: rdDataNxt = stat.lineStatus;
				ucrm_pkg::ADDR_MSTAT: rdDataNxt = stat.modemStatus;
				ucrm_pkg::ADDR_SCR: rdDataNxt = scrR;
				default: rdDataNxt = ucrm_pkg::ZERO_BYTE;
			endcase
		end
	end

	// Registered read data holds until the next read
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rdData <= ucrm_pkg::ZERO_BYTE;
		end else if (rd) begin
			rdData <= rdDataNxt;
		end
	end

	// ****************************************
	// Side-effect strobes and control out
	// ****************************************
	// Strobes tell the channel logic that a load, pop, clear or FIFO-control write is due
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			txLoad <= 1'b0;
			rxRead <= 1'b0;
			fifoWrite <= 1'b0;
			lineStatusRead <= 1'b0;
			modemStatusRead <= 1'b0;
			intStatusRead <= 1'b0;
		end else begin
			txLoad <= wr && normMode && addr == ucrm_pkg::ADDR_HOLD;
			rxRead <= rd && normMode && addr == ucrm_pkg::ADDR_HOLD;
			fifoWrite <= wr && !keyMode && !fracMode
				&& addr == ucrm_pkg::ADDR_ISTAT;
			lineStatusRead <= rd && !keyMode
				&& addr == ucrm_pkg::ADDR_LSTAT;
			modemStatusRead <= rd && !keyMode
				&& addr == ucrm_pkg::ADDR_MSTAT;
			intStatusRead <= rd && !keyMode && !fracMode
				&& addr == ucrm_pkg::ADDR_ISTAT;
		end
	end

	// Extension bits are forced low toward the channel while bit 4 clear
	always_comb begin
		ctrl.intEnable = ienR & (extKeep | ~ucrm_pkg::IEN_EXT_MASK);
		ctrl.fifoControl = fctlR & (extKeep | ~ucrm_pkg::FCTL_EXT_MASK);
		ctrl.lineControl = lctlR;
		ctrl.modemControl = mctlR & (extKeep | ~ucrm_pkg::MCTL_EXT_MASK);
		ctrl.divisorLow = divLoR;
		ctrl.divisorHigh = divHiR;
		ctrl.divisorFraction = divFrR & extKeep;
		ctrl.enhancedFunction = efnR;
		ctrl.resumeCharOne = res1R;
		ctrl.resumeCharTwo = res2R;
		ctrl.pauseCharOne = pau1R;
		ctrl.pauseCharTwo = pau2R;
	end
endmodule : ucrm_channel_regs
`default_nettype wire

// *** design/ucrm_pkg.sv ***
// Package for the UART channel register map: addresses, fields, keys.
// Assumes an 8-bit host bus with three address lines per channel.
`default_nettype none
package ucrm_pkg;
	// ****************************************
	// Addresses
	// ****************************************
	localparam logic [2:0] ADDR_HOLD = 3'h0;
	localparam logic [2:0] ADDR_IEN = 3'h1;
	localparam logic [2:0] ADDR_ISTAT = 3'h2;
	localparam logic [2:0] ADDR_LCTL = 3'h3;
	localparam logic [2:0] ADDR_MCTL = 3'h4;
	localparam logic [2:0] ADDR_LSTAT = 3'h5;
	localparam logic [2:0] ADDR_MSTAT = 3'h6;
	localparam logic [2:0] ADDR_SCR = 3'h7;
	localparam logic [2:0] ADDR_DIVLO = 3'h0;
	localparam logic [2:0] ADDR_DIVHI = 3'h1;
	localparam logic [2:0] ADDR_DIVFR = 3'h2;
	localparam logic [2:0] ADDR_EFN = 3'h2;
	localparam logic [2:0] ADDR_RES1 = 3'h4;
	localparam logic [2:0] ADDR_RES2 = 3'h5;
	localparam logic [2:0] ADDR_PAU1 = 3'h6;
	localparam logic [2:0] ADDR_PAU2 = 3'h7;
	// ****************************************
	// Keys, fields, masks
	// ****************************************
	localparam logic [7:0] LCTL_KEY = 8'hbf;
	localparam int LCTL_DIV_BIT = 7;
	localparam int EFN_EXT_BIT = 4;
	localparam logic [7:0] IEN_EXT_MASK = 8'hf0;
	localparam logic [7:0] ISTAT_EXT_MASK = 8'h30;
	localparam logic [7:0] FCTL_EXT_MASK = 8'h30;
	localparam logic [7:0] MCTL_EXT_MASK = 8'he0;
	localparam logic [7:0] DIVFR_MASK = 8'h3f;
	localparam logic [7:0] ZERO_BYTE = 8'h00;
	localparam logic [7:0] REG_RESET = 8'h00;
	// Identity values, arbitrary
	localparam logic [7:0] REV_CODE = 8'h01;
	localparam logic [7:0] DEV_ID = 8'h5a;

	// Control fields fed to the channel logic
	typedef struct packed {
		logic [7:0] intEnable;
		logic [7:0] fifoControl;
		logic [7:0] lineControl;
		logic [7:0] modemControl;
		logic [7:0] divisorLow;
		logic [7:0] divisorHigh;
		logic [7:0] divisorFraction;
		logic [7:0] enhancedFunction;
		logic [7:0] resumeCharOne;
		logic [7:0] resumeCharTwo;
		logic [7:0] pauseCharOne;
		logic [7:0] pauseCharTwo;
	} ucrm_ctrl_s;

	// Status fields supplied by the channel logic
	typedef struct packed {
		logic [7:0] receiveHolding;
		logic [7:0] interruptStatus;
		logic [7:0] lineStatus;
		logic [7:0] modemStatus;
	} ucrm_stat_s;
endpackage : ucrm_pkg
`default_nettype wire

// *** test/uart_channel_register_map_tb.sv ***
// Self-checking bench for the channel register map.
// Assumes the channel model supplies status; host bus driven here.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin nTests++; if ((g) !== (e)) begin badCount++; \
	$display("BAD %0t got %h exp %h", $time, g, e); end end
module uart_channel_register_map_tb;
	logic clk, rst, chipSel, readStb, writeStb, txLoad, rxRead, fifoWrite;
	logic lineStatusRead, intStatusRead, modemStatusRead;
	logic [2:0] addr;
	logic [7:0] wrData, rdData, transmitHolding, rx;
	ucrm_pkg::ucrm_stat_s stat;
	ucrm_pkg::ucrm_ctrl_s ctrl;
	int badCount = 0, nTests = 0, cycles = 0;
	ucrm_channel_regs uut (.clk, .rst, .chipSel, .addr, .readStb, .writeStb,
		.wrData, .rdData, .stat, .ctrl, .transmitHolding, .txLoad, .rxRead,
		.fifoWrite, .lineStatusRead, .modemStatusRead, .intStatusRead);
	ucrm_chan_model chan (.clk, .rst, .rxRead, .stat);
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	task automatic closeOut;
		$display("checks %0d mismatches %0d", nTests, badCount);
		if (badCount == 0 && nTests > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : closeOut
	// Hang guard, far above the roughly 150 cycles used
	always @(posedge clk) begin
		cycles++;
		if (cycles == 3000) begin
			badCount++;
			closeOut();
		end
	end
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wrData <= d;
		writeStb <= 1'b1;
		@(posedge clk);
		writeStb <= 1'b0;
		#1;
	endtask : wr
	task automatic rc(input logic [2:0] a, input logic [7:0] e);
		@(posedge clk);
		addr <= a;
		readStb <= 1'b1;
		@(posedge clk);
		readStb <= 1'b0;
		#1;
		`CHK(rdData, e)
	endtask : rc
	task automatic t_hold;
		wr(3'h0, 8'ha5);
		`CHK({txLoad, transmitHolding}, {1'b1, 8'ha5})
		for (int i = 0; i < 2; i++) begin
			rc(3'h0, rx);
			`CHK(rxRead, 1'b1)
			rx++;
		end
	endtask : t_hold
	task automatic t_plain;
		wr(3'h3, 8'h1b);
		rc(3'h3, 8'h1b);
		wr(3'h4, 8'hff);
		rc(3'h4, 8'h1f);
		for (int i = 0; i < 8; i++) begin
			wr(3'h7, 8'h01 << i);
			rc(3'h7, 8'h01 << i);
		end
		rc(3'h5, 8'h61);
		`CHK(lineStatusRead, 1'b1)
		rc(3'h6, 8'h0b);
		`CHK(modemStatusRead, 1'b1)
		rc(3'h2, 8'hcc);
		`CHK(intStatusRead, 1'b1)
		wr(3'h2, 8'hff);
		`CHK({fifoWrite, ctrl.fifoControl}, {1'b1, 8'hcf})
		wr(3'h1, 8'hff);
		rc(3'h1, 8'h0f);
	endtask : t_plain
	task automatic t_div;
		wr(3'h3, 8'h80);
		wr(3'h0, 8'h12);
		`CHK({txLoad, transmitHolding}, {1'b0, 8'ha5})
		wr(3'h1, 8'h34);
		rc(3'h0, 8'h12);
		rc(3'h1, 8'h34);
		rc(3'h2, 8'hcc);
		`CHK(intStatusRead, 1'b1)
		wr(3'h2, 8'h01);
		`CHK({fifoWrite, ctrl.fifoControl}, {1'b1, 8'h01})
		wr(3'h0, 8'h00);
		wr(3'h1, 8'h00);
		rc(3'h0, ucrm_pkg::REV_CODE);
		rc(3'h1, ucrm_pkg::DEV_ID);
	endtask : t_div
	task automatic t_key;
		wr(3'h3, 8'hbf);
		wr(3'h2, 8'hd0);
		rc(3'h2, 8'hd0);
		for (int i = 4; i < 8; i++) wr(i[2:0], 8'hc0 + 8'(i));
		for (int i = 4; i < 8; i++) rc(i[2:0], 8'hc0 + 8'(i));
		`CHK({ctrl.resumeCharOne, ctrl.resumeCharTwo}, 16'hc4c5)
		`CHK({ctrl.pauseCharOne, ctrl.pauseCharTwo}, 16'hc6c7)
		rc(3'h6, 8'hc6);
		`CHK(modemStatusRead, 1'b0)
		rc(3'h3, 8'hbf);
		wr(3'h3, 8'h80);
		wr(3'h2, 8'hff);
		rc(3'h2, 8'h3f);
		`CHK(ctrl.divisorFraction, 8'h3f)
		wr(3'h3, 8'h00);
		wr(3'h1, 8'hf5);
		rc(3'h1, 8'hf5);
		`CHK(ctrl.intEnable, 8'hf5)
		rc(3'h2, 8'hfc);
		wr(3'h4, 8'he0);
		rc(3'h4, 8'he0);
		`CHK(ctrl.modemControl, 8'he0)
		rc(3'h7, 8'h80);
	endtask : t_key
	task automatic t_sel;
		@(posedge clk) chipSel <= 1'b0;
		wr(3'h7, 8'h00);
		wr(3'h0, 8'h00);
		`CHK({txLoad, transmitHolding}, {1'b0, 8'ha5})
		@(posedge clk) chipSel <= 1'b1;
		rc(3'h7, 8'h80);
	endtask : t_sel
	// Mid-run reset: stores and holding byte fall back to reset values
	task automatic t_reset;
		@(posedge clk);
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		#1;
		`CHK(transmitHolding, ucrm_pkg::REG_RESET)
		`CHK(ctrl.lineControl, ucrm_pkg::REG_RESET)
		rc(3'h3, ucrm_pkg::REG_RESET);
		rc(3'h7, ucrm_pkg::REG_RESET);
		rc(3'h0, 8'h30);
	endtask : t_reset
	initial begin
		rst = 1'b1;
		{chipSel, readStb, writeStb, addr, wrData} = '0;
		rx = 8'h30;
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		chipSel <= 1'b1;
		t_hold();
		t_plain();
		t_div();
		t_key();
		t_sel();
		t_reset();
		closeOut();
	end
endmodule : uart_channel_register_map_tb
`default_nettype wire

// *** test/ucrm_chan_model.sv ***
// Channel-side model: status bytes seen by the register map.
// Assumes one clock; receive data steps on each receive-holding read.
`timescale 1ns/1ps
`default_nettype none
module ucrm_chan_model (
	input wire logic clk,
	input wire logic rst,
	input wire logic rxRead,
	output var ucrm_pkg::ucrm_stat_s stat
);
	// Next byte shows only after the read, never early
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			stat <= {8'h30, 8'hfc, 8'h61, 8'h0b};
		end else if (rxRead) begin
			stat.receiveHolding <= stat.receiveHolding + 8'h01;
		end
	end
endmodule : ucrm_chan_model
`default_nettype wire

// *** test/ucrm_channel_regs_monitor.sv ***
// Checker for the channel register map, bound to its ports.
// Assumes single clock domain and async active-high reset.
`timescale 1ns/1ps
`default_nettype none
module ucrm_channel_regs_monitor (
	input wire logic clk,
	input wire logic rst,
	input wire logic chipSel,
	input wire logic [2:0] addr,
	input wire logic readStb,
	input wire logic writeStb,
	input wire logic [7:0] wrData,
	input wire logic [7:0] rdData,
	input wire ucrm_pkg::ucrm_stat_s stat,
	input wire ucrm_pkg::ucrm_ctrl_s ctrl,
	input wire logic [7:0] transmitHolding,
	input wire logic txLoad,
	input wire logic rxRead,
	input wire logic fifoWrite,
	input wire logic intStatusRead,
	input wire logic lineStatusRead
);
	wire logic [7:0] lc = ctrl.lineControl;
	wire logic key = lc == 8'hbf;
	wire logic nm = !lc[7];
	wire logic ext = ctrl.enhancedFunction[4];
	wire logic w = chipSel && writeStb;
	wire logic r = chipSel && readStb;
	wire logic dz = (ctrl.divisorLow | ctrl.divisorHigh) == 8'h00;
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	hold_write_a: assert property (w && addr == 3'h0 && nm |=>
		txLoad && transmitHolding == $past(wrData)) else $error("tx load");
	hold_read_a: assert property (r && addr == 3'h0 && nm |=>
		rxRead && rdData == $past(stat.receiveHolding)) else $error("rx read");
	ext_gate_a: assert property (!ext |-> ((ctrl.intEnable & 8'hf0) |
		(ctrl.fifoControl & 8'h30) | (ctrl.modemControl & 8'he0) |
		ctrl.divisorFraction) == 8'h00) else $error("ext bits leak");
	div_read_a: assert property (r && addr == 3'h0 && lc[7] && !key |=>
		rdData == ($past(dz) ? ucrm_pkg::REV_CODE : $past(ctrl.divisorLow)))
		else $error("divisor read");
	lctl_write_a: assert property (w && addr == 3'h3 |=>
		lc == $past(wrData)) else $error("line control write");
	ien_write_a: assert property (w && addr == 3'h1 && nm |=>
		(ctrl.intEnable & 8'h0f) == ($past(wrData) & 8'h0f))
		else $error("int enable write");
	istat_read_a: assert property (r && addr == 3'h2 && nm |=>
		intStatusRead && rdData == ($past(stat.interruptStatus) &
		($past(ext) ? 8'hff : 8'hcf))) else $error("int status read");
	fifo_write_a: assert property (w && addr == 3'h2 && nm |=>
		fifoWrite) else $error("fifo write");
	lstat_read_a: assert property (r && addr == 3'h5 && !key |=>
		lineStatusRead && rdData == $past(stat.lineStatus))
		else $error("line status read");
	efn_write_a: assert property (w && addr == 3'h2 && key |=>
		ctrl.enhancedFunction == $past(wrData)) else $error("efn write");
	sel_gate_a: assert property (!chipSel |=> !txLoad && !rxRead &&
		!fifoWrite && !intStatusRead) else $error("unselected access");
endmodule : ucrm_channel_regs_monitor
bind ucrm_channel_regs ucrm_channel_regs_monitor mon (.clk, .rst, .chipSel,
	.addr, .readStb, .writeStb, .wrData, .rdData, .stat, .ctrl,
	.transmitHolding, .txLoad, .rxRead, .fifoWrite, .intStatusRead,
	.lineStatusRead);
`default_nettype wire
